// [design/sof_top.sv]
/*
  sof_top: switch-onto-fault logic with dead-line detection, hold window and
  a built-in per-phase overcurrent stage, configured over APB.
  Assumes magnitudes and digital inputs are synchronous to pclk (40 MHz) and
  that the APB master keeps to the standard two-phase protocol.
*/
// Notes on behaviour
// [RULE_01] external activation input arms the function; trips only while armed.
// [RULE_02] dead-line activation path enabled whenever a voltage channel other than neutral is connected.
// [RULE_03] external and dead-line activation combine as a logical OR.
// [RULE_04] after all conditions drop, stay armed for the hold window time.
// [RULE_05] active output mirrors the armed state for use by other stages.
// [RULE_06] every trip acts on all three poles.
// [RULE_07] dead line: all currents and voltages below thresholds beyond confirm time.
// [RULE_08] dead-line flag clears at once when any magnitude exceeds its threshold.
// [RULE_09] dead-line state is an output of its own.
// [RULE_10] one to three phase-earth or phase-phase voltages feed dead-line detection.
// [RULE_11] overcurrent stage has its own on/off and works only while armed.
// [RULE_12] separate comparison element and trip output for each phase current.
// [RULE_13] general overcurrent trip is the OR of the three phase trips.
// [RULE_14] phase trip asserts without delay when current exceeds operate level.
// [RULE_15] phase trip drops only below 96 percent of operate level.
// [RULE_16] operate level is per unit times rated current transformer primary current.
// [RULE_17] overcurrent inhibit input blocks the stage; inhibited status shown on output.
// [RULE_18] missing current channel or phase: no operation, health alarm.
// [RULE_19] no or neutral voltage channel: no dead-line detection, health warning.
// [RULE_20] general block input accepts any user-defined condition.
// [RULE_21] general block suppresses trips and active output, measurement keeps running.
`timescale 1ns/1ps
module sof_top
  import sof_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // measurements and digital inputs
  input  wire sof_meas_t   meas,
  input  wire logic        external_activation,
  input  wire logic        block_in,
  input  wire logic        overcurrent_inhibit_in,
  input  wire logic        voltage_transformer_fault_in,
  // protection outputs
  output sof_out_t         prot_out,
  output logic [1:0]       health,
  output logic [1:0]       behaviour,
  output logic [1:0]       overcurrent_stage_behaviour
);

  // configuration registers
  logic [11:0] ctrl_r;
  logic [15:0] hold_window_time_r;
  logic [15:0] deenergized_confirm_time_r;
  logic [15:0] dead_current_threshold_r;
  logic [15:0] dead_voltage_threshold_r;
  logic [15:0] overcurrent_operate_level_r;
  logic [15:0] rated_current_r;
  logic [15:0] rated_voltage_r;

  // bus decode
  logic        wr_en;
  logic        rd_setup;
  logic        addr_hit;
  logic [31:0] rd_nxt;
  logic [31:0] status_word;

  // tick divider
  logic [31:0] tick_cnt_r;
  logic        tick;

  // derived configuration
  logic        operation_on;
  logic        overcurrent_stage_on;
  logic        current_ok;
  logic        deadline_enabled;
  sof_health_t health_nxt;

  // scaled thresholds
  logic [31:0] dead_i_prod;
  logic [31:0] dead_u_prod;
  logic [31:0] oc_prod;
  logic [23:0] dead_i_level;
  logic [23:0] dead_u_level;
  logic [23:0] oc_level;

  // dead-line detection
  logic        currents_dead;
  logic        voltages_dead;
  logic        dead_cond;
  logic [15:0] confirm_cnt_r;
  logic        deadline_r;

  // activation window
  logic        activation_cond;
  logic [15:0] hold_cnt_r;
  logic        armed_r;

  // overcurrent stage
  logic        oc_enable;
  logic [2:0]  phase_trip;
  logic [15:0] phase_mag [3];


  // apb slave: zero wait states, read data latched in the setup cycle

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;

  always_comb
  begin
    addr_hit = 1'b1;
    rd_nxt   = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL:    rd_nxt = {20'h0_0000, ctrl_r};
      OFS_HOLD:    rd_nxt = {16'h0000, hold_window_time_r};
      OFS_CONFIRM: rd_nxt = {16'h0000, deenergized_confirm_time_r};
      OFS_DEAD_I:  rd_nxt = {16'h0000, dead_current_threshold_r};
      OFS_DEAD_U:  rd_nxt = {16'h0000, dead_voltage_threshold_r};
      OFS_OC_LVL:  rd_nxt = {16'h0000, overcurrent_operate_level_r};
      OFS_RATED_I: rd_nxt = {16'h0000, rated_current_r};
      OFS_RATED_U: rd_nxt = {16'h0000, rated_voltage_r};
      OFS_STATUS:  rd_nxt = status_word;
      default:     addr_hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= rd_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r                      <= RST_CTRL;
      hold_window_time_r          <= RST_HOLD;
      deenergized_confirm_time_r  <= RST_CONFIRM;
      dead_current_threshold_r    <= RST_DEAD_I;
      dead_voltage_threshold_r    <= RST_DEAD_U;
      overcurrent_operate_level_r <= RST_OC_LVL;
      rated_current_r             <= RST_RATED_I;
      rated_voltage_r             <= RST_RATED_U;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        OFS_CTRL:    ctrl_r                      <= pwdata[11:0] & CTRL_MASK;
        OFS_HOLD:    hold_window_time_r          <= pwdata[15:0];
        OFS_CONFIRM: deenergized_confirm_time_r  <= pwdata[15:0];
        OFS_DEAD_I:  dead_current_threshold_r    <= pwdata[15:0];
        OFS_DEAD_U:  dead_voltage_threshold_r    <= pwdata[15:0];
        OFS_OC_LVL:  overcurrent_operate_level_r <= pwdata[15:0];
        OFS_RATED_I: rated_current_r             <= pwdata[15:0];
        OFS_RATED_U: rated_voltage_r             <= pwdata[15:0];
        default:     ;
      endcase
    end
  end


  // 1 ms processing tick

  assign tick = (tick_cnt_r == TICK_DIV - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_r <= 32'h0000_0000;
    else if (tick)
      tick_cnt_r <= 32'h0000_0000;
    else
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
  end


  // configuration checks and health

  assign operation_on         = ctrl_r[CTRL_OPER_BIT];
  assign overcurrent_stage_on = ctrl_r[CTRL_OC_ON_BIT];
  assign current_ok           = ctrl_r[CTRL_I_ASGN_BIT] && (&ctrl_r[CTRL_I_PH_LSB +: 3]);   // [RULE_18]
  assign deadline_enabled     = (|ctrl_r[CTRL_U_PH_LSB +: 3])
                                && !ctrl_r[CTRL_U_NEUT_BIT];                              // [RULE_02] [RULE_19]

  always_comb
  begin
    if (!current_ok)
      health_nxt = SOF_HEALTH_ALRM;    // [RULE_18]
    else if (!deadline_enabled)
      health_nxt = SOF_HEALTH_WARN;    // [RULE_19]
    else
      health_nxt = SOF_HEALTH_OK;
  end


  // per-unit thresholds scaled to primary amps and volts

  assign dead_i_prod  = 32'(dead_current_threshold_r) * 32'(rated_current_r);
  assign dead_u_prod  = 32'(dead_voltage_threshold_r) * 32'(rated_voltage_r);
  assign oc_prod      = 32'(overcurrent_operate_level_r) * 32'(rated_current_r);   // [RULE_16]
  assign dead_i_level = dead_i_prod[PU_FRAC_BITS +: 24];
  assign dead_u_level = dead_u_prod[PU_FRAC_BITS +: 24];
  assign oc_level     = oc_prod[PU_FRAC_BITS +: 24];


  // dead-line detection

  assign currents_dead = ({8'h00, meas.ia} < dead_i_level)
                         && ({8'h00, meas.ib} < dead_i_level)
                         && ({8'h00, meas.ic} < dead_i_level);

  // only the voltage inputs that are connected take part
  assign voltages_dead = (!ctrl_r[CTRL_U_PH_LSB]     || ({8'h00, meas.ua} < dead_u_level))
                         && (!ctrl_r[CTRL_U_PH_LSB + 1] || ({8'h00, meas.ub} < dead_u_level))
                         && (!ctrl_r[CTRL_U_PH_LSB + 2] || ({8'h00, meas.uc} < dead_u_level)); // [RULE_10]

  // a failed voltage transformer would fake a dead line, so it vetoes detection
  assign dead_cond = deadline_enabled && current_ok && operation_on
                     && !voltage_transformer_fault_in
                     && currents_dead && voltages_dead;                          // [RULE_07]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      confirm_cnt_r <= 16'h0000;
      deadline_r    <= 1'b0;
    end
    else if (!dead_cond)
    begin
      confirm_cnt_r <= 16'h0000;
      deadline_r    <= 1'b0;                                                   // [RULE_08]
    end
    else if (tick && !deadline_r)
    begin
      if (confirm_cnt_r > deenergized_confirm_time_r)
        deadline_r <= 1'b1;                                                    // [RULE_07]
      else
        confirm_cnt_r <= confirm_cnt_r + 16'h0001;
    end
  end


  // activation window

  assign activation_cond = operation_on && current_ok
                           && (external_activation || deadline_r);             // [RULE_01] [RULE_03]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      armed_r    <= 1'b0;
      hold_cnt_r <= 16'h0000;
    end
    else if (activation_cond)
    begin
      armed_r    <= 1'b1;                                                      // [RULE_01]
      hold_cnt_r <= hold_window_time_r;
    end
    else if (!operation_on || !current_ok)
    begin
      armed_r    <= 1'b0;
      hold_cnt_r <= 16'h0000;
    end
    else if (armed_r && tick)
    begin
      if (hold_cnt_r <= 16'h0001)
      begin
        armed_r    <= 1'b0;                                                    // [RULE_04]
        hold_cnt_r <= 16'h0000;
      end
      else
        hold_cnt_r <= hold_cnt_r - 16'h0001;                                   // [RULE_04]
    end
  end


  // built-in overcurrent stage, one element per phase

  assign oc_enable = armed_r && overcurrent_stage_on && operation_on && current_ok
                     && !overcurrent_inhibit_in && !block_in;                  // [RULE_11] [RULE_17] [RULE_21]

  assign phase_mag[0] = meas.ia;
  assign phase_mag[1] = meas.ib;
  assign phase_mag[2] = meas.ic;

  for (genvar ph = 0; ph < 3; ph++)
  begin : g_phase
    sof_phase_oc u_oc (                                                         // [RULE_12]
      .pclk      (pclk),
      .presetn   (presetn),
      .enable    (oc_enable),
      .magnitude (phase_mag[ph]),
      .level     (oc_level),
      .trip_r    (phase_trip[ph])
    );
  end


  // outputs

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prot_out                    <= '0;
      health                      <= SOF_HEALTH_OK;
      behaviour                   <= SOF_BEH_OFF;
      overcurrent_stage_behaviour <= SOF_BEH_OFF;
    end
    else
    begin
      prot_out.active                    <= armed_r && !block_in;             // [RULE_05] [RULE_21]
      prot_out.line_deenergized_flag     <= deadline_r && !block_in;          // [RULE_09]
      prot_out.phase_trip                <= phase_trip;                       // [RULE_12]
      prot_out.general_overcurrent_trip  <= |phase_trip;                      // [RULE_13] [RULE_06]
      prot_out.blocked                   <= block_in;                         // [RULE_20] [RULE_21]
      prot_out.overcurrent_inhibited_out <= overcurrent_inhibit_in;           // [RULE_17]
      health                             <= health_nxt;
      behaviour                          <= !operation_on ? SOF_BEH_OFF
                                            : (block_in ? SOF_BEH_BLOCKED : SOF_BEH_ON);
      overcurrent_stage_behaviour        <= !(operation_on && overcurrent_stage_on) ? SOF_BEH_OFF
                                            : ((block_in || overcurrent_inhibit_in)
                                               ? SOF_BEH_BLOCKED : SOF_BEH_ON);
    end
  end

  always_comb
  begin
    status_word                      = 32'h0000_0000;
    status_word[ST_ACTIVE_BIT]       = prot_out.active;
    status_word[ST_DEAD_BIT]         = prot_out.line_deenergized_flag;
    status_word[ST_TRIP_LSB +: 3]    = prot_out.phase_trip;
    status_word[ST_GTRIP_BIT]        = prot_out.general_overcurrent_trip;
    status_word[ST_BLK_BIT]          = prot_out.blocked;
    status_word[ST_OCBLK_BIT]        = prot_out.overcurrent_inhibited_out;
    status_word[ST_HEALTH_LSB +: 2]  = health;
    status_word[ST_BEHAV_LSB +: 2]   = behaviour;
    status_word[ST_OCBEHAV_LSB +: 2] = overcurrent_stage_behaviour;
  end

endmodule : sof_top

// [design/sof_pkg.sv]
/*
  sof_pkg: constants, register map, field positions and carrier types of the
  switch-onto-fault block.
  Assumes a 40 MHz pclk and an APB register bus with 32-bit data.
*/
package sof_pkg;

  // clock and processing tick
  localparam int unsigned CLK_PERIOD_PS = 25_000;
  localparam int unsigned TICK_PERIOD_US = 1_000;
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_US * 1_000_000) / CLK_PERIOD_PS;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_HOLD    = 8'h04;
  localparam logic [7:0] OFS_CONFIRM = 8'h08;
  localparam logic [7:0] OFS_DEAD_I  = 8'h0C;
  localparam logic [7:0] OFS_DEAD_U  = 8'h10;
  localparam logic [7:0] OFS_OC_LVL  = 8'h14;
  localparam logic [7:0] OFS_RATED_I = 8'h18;
  localparam logic [7:0] OFS_RATED_U = 8'h1C;
  localparam logic [7:0] OFS_STATUS  = 8'h20;

  // control register fields
  localparam int unsigned CTRL_OPER_BIT   = 0;
  localparam int unsigned CTRL_OC_ON_BIT  = 1;
  localparam int unsigned CTRL_I_PH_LSB   = 4;
  localparam int unsigned CTRL_I_ASGN_BIT = 7;
  localparam int unsigned CTRL_U_PH_LSB   = 8;
  localparam int unsigned CTRL_U_NEUT_BIT = 11;
  localparam logic [11:0] CTRL_MASK       = 12'h0F_F3;

  // status register fields
  localparam int unsigned ST_ACTIVE_BIT  = 0;
  localparam int unsigned ST_DEAD_BIT    = 1;
  localparam int unsigned ST_TRIP_LSB    = 2;
  localparam int unsigned ST_GTRIP_BIT   = 5;
  localparam int unsigned ST_BLK_BIT     = 6;
  localparam int unsigned ST_OCBLK_BIT   = 7;
  localparam int unsigned ST_HEALTH_LSB  = 8;
  localparam int unsigned ST_BEHAV_LSB   = 10;
  localparam int unsigned ST_OCBEHAV_LSB = 12;

  // reset values: times in ms, levels per unit in Q8.8, ratings in amps / volts
  localparam logic [11:0] RST_CTRL    = 12'h0_00;
  localparam logic [15:0] RST_HOLD    = 16'h01F4;
  localparam logic [15:0] RST_CONFIRM = 16'h03E8;
  localparam logic [15:0] RST_DEAD_I  = 16'h0019;
  localparam logic [15:0] RST_DEAD_U  = 16'h0033;
  localparam logic [15:0] RST_OC_LVL  = 16'h0200;
  localparam logic [15:0] RST_RATED_I = 16'h0001;
  localparam logic [15:0] RST_RATED_U = 16'h0001;

  // per-unit scaling and reset hysteresis of 96 % = 24 / 25
  localparam int unsigned PU_FRAC_BITS = 8;
  localparam logic [4:0]  HYST_NUM     = 5'h18;
  localparam logic [4:0]  HYST_DEN     = 5'h19;

  typedef enum logic [1:0] {
    SOF_HEALTH_OK   = 2'b00,
    SOF_HEALTH_WARN = 2'b01,
    SOF_HEALTH_ALRM = 2'b10
  } sof_health_t;

  typedef enum logic [1:0] {
    SOF_BEH_OFF     = 2'b00,
    SOF_BEH_ON      = 2'b01,
    SOF_BEH_BLOCKED = 2'b10
  } sof_behav_t;

  // magnitudes from the measurement channels, one per processing sample
  typedef struct packed {
    logic [15:0] ia;
    logic [15:0] ib;
    logic [15:0] ic;
    logic [15:0] ua;
    logic [15:0] ub;
    logic [15:0] uc;
  } sof_meas_t;

  typedef struct packed {
    logic       active;
    logic       line_deenergized_flag;
    logic [2:0] phase_trip;
    logic       general_overcurrent_trip;
    logic       blocked;
    logic       overcurrent_inhibited_out;
  } sof_out_t;

endpackage : sof_pkg

// [design/sof_phase_oc.sv]
/*
  sof_phase_oc: one instantaneous overcurrent element with reset hysteresis.
  Assumes the operate level is already scaled to the units of the magnitude.
*/
`timescale 1ns/1ps
module sof_phase_oc
  import sof_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // element inputs
  input  wire logic        enable,
  input  wire logic [15:0] magnitude,
  input  wire logic [23:0] level,
  // element output
  output logic             trip_r
);

  logic [20:0] mag_scaled;
  logic [28:0] lvl_scaled;
  logic        over_level;
  logic        below_reset;

  assign over_level  = {8'h00, magnitude} > level;
  assign mag_scaled  = 21'(magnitude) * 21'(HYST_DEN);
  assign lvl_scaled  = 29'(level) * 29'(HYST_NUM);
  assign below_reset = {8'h00, mag_scaled} < lvl_scaled;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trip_r <= 1'b0;
    else if (!enable)
      trip_r <= 1'b0;
    else if (over_level)
      trip_r <= 1'b1;        // [RULE_14]
    else if (below_reset)
      trip_r <= 1'b0;        // [RULE_15]
  end

endmodule : sof_phase_oc

// [sim/sof_asserts.sv]
/*
  sof_asserts: concurrent checks on the protection ports of sof_top.
  Assumes it is bound into sof_top and that everything runs on pclk.
*/
`timescale 1ns/1ps
module sof_asserts
  import sof_pkg::*;
(
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // watched inputs
  input wire logic       external_activation,
  input wire logic       block_in,
  input wire logic       overcurrent_inhibit_in,
  input wire logic       voltage_transformer_fault_in,
  // watched outputs
  input wire sof_out_t   prot_out,
  input wire logic [1:0] health,
  input wire logic [1:0] behaviour,
  input wire logic [1:0] overcurrent_stage_behaviour
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ext_go;
    (external_activation && behaviour == SOF_BEH_ON && health == SOF_HEALTH_OK && !block_in) ##1 !block_in[*2];
  endsequence
  sequence s_blk3;
    block_in[*3];
  endsequence
  a_ext_arms: assert property (s_ext_go |-> prot_out.active)
    else $error("active missing after external activation");
  a_trip_armed: assert property (|prot_out.phase_trip |-> prot_out.active || $past(prot_out.active))
    else $error("phase trip while not active");
  a_general_or: assert property (prot_out.general_overcurrent_trip == (|prot_out.phase_trip))
    else $error("general trip differs from phase trips");
  a_block_quiet: assert property (s_blk3 |-> prot_out.blocked && !prot_out.active &&
    !prot_out.line_deenergized_flag && prot_out.phase_trip == 3'h0)
    else $error("outputs not suppressed under block");
  a_inhibit_quiet: assert property (overcurrent_inhibit_in[*3] |->
    prot_out.overcurrent_inhibited_out && prot_out.phase_trip == 3'h0)
    else $error("overcurrent stage not inhibited");
  a_active_cause: assert property ($rose(prot_out.active) |-> $past(external_activation, 2) ||
    $past(prot_out.line_deenergized_flag) || $past(prot_out.blocked))
    else $error("active rose without a cause");
  a_fall_clears: assert property ($fell(prot_out.active) |=> prot_out.phase_trip == 3'h0)
    else $error("trip outlived the active window");
  a_vt_veto: assert property (voltage_transformer_fault_in |-> ##2 !prot_out.line_deenergized_flag)
    else $error("dead line shown during voltage fault");
  a_alarm_quiet: assert property (health == SOF_HEALTH_ALRM [*4] |-> !prot_out.active &&
    prot_out.phase_trip == 3'h0 && !prot_out.line_deenergized_flag)
    else $error("operation despite health alarm");
  a_ocoff_quiet: assert property (overcurrent_stage_behaviour != SOF_BEH_ON [*3] |->
    prot_out.phase_trip == 3'h0)
    else $error("trip while overcurrent stage not on");
endmodule : sof_asserts

// [sim/sof_line_model.sv]
/*
  sof_line_model: the feeder side: breaker close command and magnitudes.
  Assumes one bench process calls its tasks; every change follows pclk.
*/
`timescale 1ns/1ps
module sof_line_model
  import sof_pkg::*;
(
  // clock
  input wire logic pclk,
  // towards the block
  output sof_meas_t meas,
  output logic      external_activation
);
  initial
  begin
    meas = '0;
    external_activation = 1'b0;
  end
  task automatic close_cmd(input logic on);
    @(posedge pclk);
    external_activation <= on;
  endtask : close_cmd
  // one magnitude per phase current, one shared by all voltages
  task automatic set_line(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input logic [15:0] u);
    @(posedge pclk);
    meas <= '{a, b, c, u, u, u};
  endtask : set_line
endmodule : sof_line_model

// [sim/sof_top_test.sv]
/*
  sof_top_test: directed scenarios for sof_top over APB and protection ports.
  Assumes TICK_DIV of 10: timers count ticks of 10 pclk cycles.
*/
`timescale 1ns/1ps
module sof_top_test
  import sof_pkg::*;
;
  logic        pclk     = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        block_in;
  logic        oc_inh;
  logic        vt_flt;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_act;
  logic [1:0]  health;
  logic [1:0]  behaviour;
  logic [1:0]  oc_beh;
  sof_meas_t   meas;
  sof_out_t    prot_out;
  logic [31:0] rd;
  logic        er;
  int          fails    = 0;
  int          checked  = 0;
  always #12.5 pclk = ~pclk;
  sof_top #(.TICK_DIV(10)) u_sof_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .external_activation(ext_act), .block_in(block_in), .overcurrent_inhibit_in(oc_inh),
    .voltage_transformer_fault_in(vt_flt), .prot_out(prot_out), .health(health), .behaviour(behaviour),
    .overcurrent_stage_behaviour(oc_beh));
  sof_line_model u_sof_line_model (.pclk(pclk), .meas(meas), .external_activation(ext_act));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic look(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : look
  task automatic pulse_close();
    u_sof_line_model.close_cmd(1'b1);
    u_sof_line_model.close_cmd(1'b0);
    look(1);
  endtask : pulse_close
  task automatic idle_line();
    u_sof_line_model.set_line(16'h0064, 16'h0064, 16'h0064, 16'h03E8);
  endtask : idle_line
  task automatic t_regs();
    idle_line();
    apb(1'b0, OFS_HOLD, 32'h0);
    chk(rd, {16'h0, RST_HOLD});
    apb(1'b0, OFS_OC_LVL, 32'h0);
    chk(rd, {16'h0, RST_OC_LVL});
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, OFS_CTRL, 32'hFFFF_FFFF);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, {20'h0, CTRL_MASK});
    apb(1'b1, OFS_RATED_I, 32'h0000_0100);
    apb(1'b1, OFS_RATED_U, 32'h0000_0100);
    apb(1'b1, OFS_HOLD, 32'h3);
    apb(1'b1, OFS_CONFIRM, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h0000_07F3);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[9:8]), 32'(SOF_HEALTH_OK));
    $display("test regs done");
  endtask : t_regs
  task automatic t_ext();
    int n;
    n = 0;
    pulse_close();
    chk(32'(prot_out.active), 32'h1);
    while (prot_out.active === 1'b1 && n < 60)
    begin
      look(1);
      n++;
    end
    chk(32'(n >= 18 && n <= 31), 32'h1);
    $display("test ext done");
  endtask : t_ext
  task automatic t_oc();
    u_sof_line_model.close_cmd(1'b1);
    u_sof_line_model.set_line(16'h0064, 16'h0258, 16'h0064, 16'h03E8);
    look(2);
    chk(32'(prot_out.phase_trip), 32'h2);
    chk(32'(prot_out.general_overcurrent_trip), 32'h1);
    u_sof_line_model.set_line(16'h0064, 16'h01F4, 16'h0064, 16'h03E8);
    look(3);
    chk(32'(prot_out.phase_trip), 32'h2);
    u_sof_line_model.set_line(16'h0064, 16'h01E0, 16'h0064, 16'h03E8);
    look(2);
    chk(32'(prot_out.phase_trip), 32'h0);
    u_sof_line_model.set_line(16'h0258, 16'h0258, 16'h0258, 16'h03E8);
    look(2);
    chk(32'(prot_out.phase_trip), 32'h7);
    @(posedge pclk);
    oc_inh <= 1'b1;
    look(3);
    chk(32'(prot_out.phase_trip), 32'h0);
    chk(32'(prot_out.overcurrent_inhibited_out), 32'h1);
    @(posedge pclk) oc_inh <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0000_07F1);
    look(2);
    chk(32'(prot_out.phase_trip), 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0000_07F3);
    look(2);
    chk(32'(prot_out.phase_trip), 32'h7);
    u_sof_line_model.close_cmd(1'b0);
    look(40);
    chk(32'(prot_out.phase_trip), 32'h0);
    idle_line();
    $display("test oc done");
  endtask : t_oc
  task automatic t_dead();
    int n = 0;
    apb(1'b1, OFS_CTRL, 32'h0000_01F3);
    u_sof_line_model.set_line(16'h0, 16'h0, 16'h0, 16'h0);
    while (prot_out.line_deenergized_flag !== 1'b1 && n < 80)
    begin
      look(1);
      n++;
    end
    chk(32'(n >= 20 && n < 45), 32'h1);
    look(2);
    chk(32'(prot_out.active), 32'h1);
    u_sof_line_model.set_line(16'h0, 16'h0, 16'h0, 16'h0064);
    look(2);
    chk(32'(prot_out.line_deenergized_flag), 32'h0);
    @(posedge pclk) vt_flt <= 1'b1;
    u_sof_line_model.set_line(16'h0, 16'h0, 16'h0, 16'h0);
    look(50);
    chk(32'(prot_out.line_deenergized_flag), 32'h0);
    idle_line();
    vt_flt <= 1'b0;
    look(40);
    $display("test dead done");
  endtask : t_dead
  task automatic t_block();
    u_sof_line_model.close_cmd(1'b1);
    u_sof_line_model.set_line(16'h0258, 16'h0064, 16'h0064, 16'h03E8);
    block_in <= 1'b1;
    look(3);
    chk(32'(prot_out.active), 32'h0);
    chk(32'(prot_out.phase_trip), 32'h0);
    chk(32'(prot_out.blocked), 32'h1);
    chk(32'(behaviour), 32'(SOF_BEH_BLOCKED));
    @(posedge pclk) block_in <= 1'b0;
    look(3);
    chk(32'(prot_out.phase_trip), 32'h1);
    u_sof_line_model.close_cmd(1'b0);
    idle_line();
    look(40);
    $display("test block done");
  endtask : t_block
  task automatic t_health();
    apb(1'b1, OFS_CTRL, 32'h0000_0773);
    pulse_close();
    look(1);
    chk(32'(health), 32'(SOF_HEALTH_ALRM));
    chk(32'(prot_out.active), 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0000_00F3);
    look(2);
    chk(32'(health), 32'(SOF_HEALTH_WARN));
    pulse_close();
    chk(32'(prot_out.active), 32'h1);
    u_sof_line_model.set_line(16'h0, 16'h0, 16'h0, 16'h0);
    look(60);
    chk(32'(prot_out.line_deenergized_flag), 32'h0);
    idle_line();
    apb(1'b1, OFS_CTRL, 32'h0000_07F3);
    $display("test health done");
  endtask : t_health
  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, block_in, oc_inh, vt_flt} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ext();
    t_oc();
    t_dead();
    t_block();
    t_health();
    summarize();
  end
  initial
  begin
    repeat (6000) @(posedge pclk);
    fails++;
    summarize();
  end
endmodule : sof_top_test
bind sof_top sof_asserts u_sof_asserts (.pclk(pclk), .presetn(presetn), .external_activation(external_activation),
  .block_in(block_in), .overcurrent_inhibit_in(overcurrent_inhibit_in), .prot_out(prot_out),
  .voltage_transformer_fault_in(voltage_transformer_fault_in), .health(health), .behaviour(behaviour),
  .overcurrent_stage_behaviour(overcurrent_stage_behaviour));
